/* rtl/ess_seq.sv */
// Exposure, shutter and readout sequencer with an AXI4-Lite register slave
// What this block does
// R1: Continuous mode opens shutter right after readout, for the exposure time.
// R2: Continuous mode ignores every pulse on the trigger input.
// R3: Sync output carries shutter state or active-low readout, chosen by software.
// R4: Triggered normal mode waits for a trigger, then exposes for set time.
// R5: Normal timing closes shutter at exposure end, then reads out.
// R6: Trigger is an edge; software picks rising or falling.
// R7: Trigger source fires at least 26 ms ahead of the light event.
// R8: Early-open works only in triggered mode; opens when ready for trigger.
// R9: Early-open opens the shutter before any trigger, once ready.
// R10: Early-open keeps shutter open for exposure after trigger, then reads out.
// R11: Early-open reopens the shutter after readout and waits for trigger.
// R12: Trigger still active when readout ends starts another cycle.
// R13: Disable settings hold shutter open or closed for the whole run.
// R14: After one begin command all frames are taken without host help.
// R15: Exposure is timed by a counter loaded with the exposure time.
// R16: Readout starts only after a programmed shutter settling time.
`timescale 1ns/100ps
module ess_seq #(
    parameter int AW = 8,
    parameter int CW = 32
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          nrst,
    // AXI4-Lite write address
    input  wire logic          s_axi_awvalid,
    output      logic          s_axi_awready,
    input  wire logic [AW-1:0] s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic          s_axi_wvalid,
    output      logic          s_axi_wready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    // AXI4-Lite write response
    output      logic          s_axi_bvalid,
    input  wire logic          s_axi_bready,
    output      logic [1:0]    s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic          s_axi_arvalid,
    output      logic          s_axi_arready,
    input  wire logic [AW-1:0] s_axi_araddr,
    // AXI4-Lite read data
    output      logic          s_axi_rvalid,
    input  wire logic          s_axi_rready,
    output      logic [31:0]   s_axi_rdata,
    output      logic [1:0]    s_axi_rresp,
    // Experiment side pins
    input  wire logic          ext_trig,
    output      logic          shutter_open,
    output      logic          sync_out,
    // Detector readout handshake
    output      logic          readout_busy,
    output      logic          readout_start,
    input  wire logic          readout_done
);

    // Merge a write into a register under the byte strobes
    function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : strb_merge

    // Reset release through two flip-flops
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Bus side storage
    logic          aw_held;
    logic          w_held;
    logic [7:0]    aw_addr_q;
    logic [31:0]   w_data_q;
    logic [3:0]    w_strb_q;
    localparam int CTRL_LEN = ess_pkg::CTRL_W;
    logic [CTRL_LEN-1:0] ctrl;
    logic [CW-1:0] exp_cycles;
    logic [CW-1:0] settle_cycles;
    logic [31:0]   frame_total;
    logic [31:0]   frames_done;

    // Sequencer storage
    ess_pkg::ess_state_e state;
    ess_pkg::ess_state_e next_state;
    logic          trig_meta;
    logic          trig_sync;
    logic          trig_act_q;
    logic          trig_active;
    logic          tmr_load;
    logic [CW-1:0] tmr_val;
    logic          tmr_done;
    logic          next_shutter;

    // Write channel handshakes and decode
    wire        wr_fire   = aw_held && w_held && !s_axi_bvalid;
    wire        wr_ctrl   = wr_fire && (aw_addr_q == ess_pkg::OFS_CTRL);
    wire        wr_cmd    = wr_fire && (aw_addr_q == ess_pkg::OFS_CMD);
    wire        wr_exp    = wr_fire && (aw_addr_q == ess_pkg::OFS_EXPOSURE);
    wire        wr_settle = wr_fire && (aw_addr_q == ess_pkg::OFS_SETTLE);
    wire        wr_frames = wr_fire && (aw_addr_q == ess_pkg::OFS_FRAMES);
    wire        wr_ro     = wr_fire && ((aw_addr_q == ess_pkg::OFS_STATUS) ||
                                        (aw_addr_q == ess_pkg::OFS_DONE_CNT));
    wire        wr_hit    = wr_ctrl || wr_cmd || wr_exp || wr_settle ||
                            wr_frames || wr_ro;
    wire        cmd_begin = wr_cmd && w_strb_q[0] &&
                            w_data_q[ess_pkg::CMD_BEGIN];
    wire        cmd_abort = wr_cmd && w_strb_q[0] &&
                            w_data_q[ess_pkg::CMD_ABORT];
    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;
    assign s_axi_arready = !s_axi_rvalid;

    // Control fields
    wire       trig_mode  = ctrl[ess_pkg::CTRL_TRIG_MODE];
    wire       rising_sel = ctrl[ess_pkg::CTRL_RISING_EDGE];
    wire       sync_sel   = ctrl[ess_pkg::CTRL_SYNC_SEL];
    wire [1:0] shut_mode  = ctrl[ess_pkg::CTRL_SHUT_MSB:ess_pkg::CTRL_SHUT_LSB];
    // R8: early open
    wire       early_eff  = trig_mode && ctrl[ess_pkg::CTRL_EARLY_OPEN];

    // Address and data capture, write response
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr_q    <= 8'h00;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= ess_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held   <= 1'b1;
                aw_addr_q <= 8'(s_axi_awaddr);
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held   <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? ess_pkg::RESP_OKAY
                                       : ess_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl          <= ess_pkg::RST_CTRL;
            exp_cycles    <= CW'(ess_pkg::RST_EXPOSURE);
            settle_cycles <= CW'(ess_pkg::RST_SETTLE);
            frame_total   <= ess_pkg::RST_FRAMES;
        end else begin
            if (wr_ctrl && w_strb_q[0]) begin
                ctrl <= w_data_q[CTRL_LEN-1:0];
            end
            if (wr_exp) begin
                exp_cycles <= CW'(strb_merge(32'(exp_cycles), w_data_q,
                                             w_strb_q));
            end
            if (wr_settle) begin
                settle_cycles <= CW'(strb_merge(32'(settle_cycles), w_data_q,
                                                w_strb_q));
            end
            if (wr_frames) begin
                frame_total <= strb_merge(frame_total, w_data_q, w_strb_q);
            end
        end
    end

    // Read data selection
    logic [31:0] rd_mux;
    logic        rd_hit;
    wire  [7:0]  ra = 8'(s_axi_araddr);
    always_comb begin
        rd_hit = 1'b1;
        if (ra == ess_pkg::OFS_CTRL) begin
            rd_mux = 32'(ctrl);
        end else if (ra == ess_pkg::OFS_CMD) begin
            rd_mux = 32'h0000_0000;
        end else if (ra == ess_pkg::OFS_EXPOSURE) begin
            rd_mux = 32'(exp_cycles);
        end else if (ra == ess_pkg::OFS_SETTLE) begin
            rd_mux = 32'(settle_cycles);
        end else if (ra == ess_pkg::OFS_FRAMES) begin
            rd_mux = frame_total;
        end else if (ra == ess_pkg::OFS_STATUS) begin
            rd_mux = {24'h00_0000, readout_busy, shutter_open, trig_act_q,
                      (state != ess_pkg::ST_IDLE), 1'b0, 3'(state)};
        end else if (ra == ess_pkg::OFS_DONE_CNT) begin
            rd_mux = frames_done;
        end else begin
            rd_mux = 32'h0000_0000;
            rd_hit = 1'b0;
        end
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= ess_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? ess_pkg::RESP_OKAY
                                   : ess_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Trigger pin through two flip-flops, then edge history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_meta  <= 1'b0;
            trig_sync  <= 1'b0;
            trig_act_q <= 1'b1;  // No false edge at release
        end else begin
            trig_meta  <= ext_trig;
            trig_sync  <= trig_meta;
            trig_act_q <= trig_active;
        end
    end

    // R6: edge select
    assign trig_active = rising_sel ? trig_sync : !trig_sync;
    wire trig_edge   = trig_active && !trig_act_q;
    wire last_frame  = (frame_total != 32'h0000_0000) &&
                       (frames_done + 32'h0000_0001 >= frame_total);
    wire ro_end      = (state == ess_pkg::ST_READOUT) && readout_done;

    // R15: exposure counter
    ess_timer #(
        .W        (CW)
    ) u_timer (
        .clk      (clk),
        .rst_n    (rst_n),
        .load     (tmr_load),
        .load_val (tmr_val),
        .done     (tmr_done)
    );

    // Next state and timer loading
    always_comb begin
        next_state = state;
        tmr_load   = 1'b0;
        tmr_val    = exp_cycles;
        case (state)
            ess_pkg::ST_IDLE: begin
                // R14: one begin runs all
                if (cmd_begin) begin
                    if (trig_mode) begin
                        next_state = ess_pkg::ST_ARM;
                    end else begin
                        next_state = ess_pkg::ST_EXPOSE;
                        tmr_load   = 1'b1;
                    end
                end
            end
            ess_pkg::ST_ARM: begin
                // R4: wait for trigger
                if (trig_edge) begin
                    next_state = ess_pkg::ST_EXPOSE;
                    tmr_load   = 1'b1;
                end
            end
            ess_pkg::ST_EXPOSE: begin
                // R5: close then settle
                if (tmr_done) begin
                    next_state = ess_pkg::ST_SETTLE;
                    tmr_load   = 1'b1;
                    tmr_val    = settle_cycles;
                end
            end
            ess_pkg::ST_SETTLE: begin
                // R16: settle before readout
                if (tmr_done) begin
                    next_state = ess_pkg::ST_READOUT;
                end
            end
            ess_pkg::ST_READOUT: begin
                if (readout_done) begin
                    if (last_frame) begin
                        next_state = ess_pkg::ST_IDLE;
                    // R2: trigger ignored, R12: level retrigger
                    end else if (!trig_mode || trig_active) begin
                        next_state = ess_pkg::ST_EXPOSE;
                        tmr_load   = 1'b1;
                    end else begin
                        // R11: back to waiting
                        next_state = ess_pkg::ST_ARM;
                    end
                end
            end
            default: begin
                next_state = ess_pkg::ST_IDLE;
            end
        endcase
        if (cmd_abort) begin
            next_state = ess_pkg::ST_IDLE;
            tmr_load   = 1'b0;
        end
    end

    // R13: disable settings, R9: early open, R1: open to expose
    // R10: open through exposure
    always_comb begin
        case (shut_mode)
            ess_pkg::SHUT_DIS_OPEN: next_shutter = 1'b1;
            ess_pkg::SHUT_DIS_SHUT: next_shutter = 1'b0;
            default: next_shutter = (next_state == ess_pkg::ST_EXPOSE) ||
                                    (early_eff &&
                                     next_state == ess_pkg::ST_ARM);
        endcase
    end

    // State, pins and frame count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state         <= ess_pkg::ST_IDLE;
            shutter_open  <= 1'b0;
            sync_out      <= 1'b1;
            readout_busy  <= 1'b0;
            readout_start <= 1'b0;
            frames_done   <= 32'h0000_0000;
        end else begin
            state         <= next_state;
            shutter_open  <= next_shutter;
            // R3: sync source select
            sync_out      <= sync_sel ? next_shutter
                                      : (next_state != ess_pkg::ST_READOUT);
            readout_busy  <= (next_state == ess_pkg::ST_READOUT);
            readout_start <= (next_state == ess_pkg::ST_READOUT) &&
                             (state != ess_pkg::ST_READOUT);
            if (cmd_begin && state == ess_pkg::ST_IDLE) begin
                frames_done <= 32'h0000_0000;
            end else if (ro_end) begin
                frames_done <= frames_done + 32'h0000_0001;
            end
        end
    end

    // Checks on the sequencer
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_ro_more;
        ro_end && !last_frame && !cmd_abort;
    endsequence

    a_cont_back_to_back: assert property ( // R1
        s_ro_more and !trig_mode |=> state == ess_pkg::ST_EXPOSE &&
            (shut_mode != ess_pkg::SHUT_NORMAL || shutter_open))
        else $error("continuous mode did not reopen after readout");

    a_cont_no_arm: assert property ( // R2
        !trig_mode && $stable(ctrl) && state != ess_pkg::ST_ARM
            |=> state != ess_pkg::ST_ARM)
        else $error("continuous mode entered trigger wait");

    a_sync_follows: assert property ( // R3
        ##1 sync_out == ($past(sync_sel) ? shutter_open : !readout_busy))
        else $error("sync output does not match its source");

    a_norm_waits: assert property ( // R4
        state == ess_pkg::ST_ARM && !trig_edge && !cmd_abort
            |=> state == ess_pkg::ST_ARM)
        else $error("left trigger wait without an edge");

    a_edge_starts: assert property ( // R6
        state == ess_pkg::ST_ARM && trig_edge && !cmd_abort
            |=> state == ess_pkg::ST_EXPOSE)
        else $error("trigger edge did not start exposure");

    a_close_settle: assert property ( // R5
        state == ess_pkg::ST_EXPOSE && tmr_done && !cmd_abort &&
            shut_mode == ess_pkg::SHUT_NORMAL
            |=> !shutter_open && state == ess_pkg::ST_SETTLE
            ##1 (state == ess_pkg::ST_SETTLE || $past(cmd_abort) ||
                 $past(settle_cycles, 2) == '0))
        else $error("shutter not closed into settling");

    a_early_opens: assert property ( // R9
        state == ess_pkg::ST_ARM && $past(early_eff) &&
            $past(shut_mode) == ess_pkg::SHUT_NORMAL |-> shutter_open)
        else $error("early open shutter closed while waiting");

    a_level_retrig: assert property ( // R12
        s_ro_more and trig_mode && trig_active
            |=> state == ess_pkg::ST_EXPOSE)
        else $error("active trigger level did not retrigger");

    a_disable_hold: assert property ( // R13
        shut_mode == ess_pkg::SHUT_DIS_SHUT && $stable(ctrl) |=> !shutter_open)
        else $error("shutter moved while disabled closed");

    a_auto_frames: assert property ( // R14
        s_ro_more |=> state != ess_pkg::ST_IDLE)
        else $error("run stopped before the last frame");

endmodule : ess_seq

/* inc/ess_pkg.sv */
// Constants and types shared by the exposure and shutter sequencer
package ess_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_CMD       = 8'h04;
    localparam logic [7:0] OFS_EXPOSURE  = 8'h08;
    localparam logic [7:0] OFS_SETTLE    = 8'h0C;
    localparam logic [7:0] OFS_FRAMES    = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h14;
    localparam logic [7:0] OFS_DONE_CNT  = 8'h18;

    // Control register field positions
    localparam int CTRL_TRIG_MODE   = 0;
    localparam int CTRL_EARLY_OPEN  = 1;
    localparam int CTRL_RISING_EDGE = 2;
    localparam int CTRL_SHUT_LSB    = 3;
    localparam int CTRL_SHUT_MSB    = 4;
    localparam int CTRL_SYNC_SEL    = 5;
    localparam int CTRL_W           = 6;

    // Command register field positions
    localparam int CMD_BEGIN = 0;
    localparam int CMD_ABORT = 1;

    // Shutter handling modes
    localparam logic [1:0] SHUT_NORMAL   = 2'h0;
    localparam logic [1:0] SHUT_DIS_OPEN = 2'h1;
    localparam logic [1:0] SHUT_DIS_SHUT = 2'h2;

    // Reset values
    localparam logic [CTRL_W-1:0] RST_CTRL     = 6'h00;
    localparam logic [31:0]       RST_EXPOSURE = 32'h0000_0064;
    localparam logic [31:0]       RST_SETTLE   = 32'h0000_0010;
    localparam logic [31:0]       RST_FRAMES   = 32'h0000_0001;

    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARM,
        ST_EXPOSE,
        ST_SETTLE,
        ST_READOUT
    } ess_state_e;

endpackage : ess_pkg

/* rtl/ess_timer.sv */
// Loadable down counter that times exposure and shutter settling
`timescale 1ns/100ps
module ess_timer #(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Load and status
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output      logic         done
);

    logic [W-1:0] cnt;

    // Count down to zero and hold there
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (load) begin
            cnt <= load_val;
        end else if (cnt != '0) begin
            cnt <= cnt - W'(1);
        end
    end

    // Expired when the count has run out
    assign done = (cnt == '0);

endmodule : ess_timer

/* testbench/ess_far_model.sv */
// Far side model: experiment trigger source and detector readout timing
`timescale 1ns/100ps
module ess_far_model #(
    parameter int RD_LEN = 8
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Trigger control from the bench
    input  wire logic trig_act,
    input  wire logic rising_sel,
    // Pins toward the sequencer
    input  wire logic readout_start,
    output      logic ext_trig,
    output      logic readout_done
);
    int cnt;

    // trigger lead time
    // Pin rests at the inactive level; the bench drives it active well ahead
    assign ext_trig = rising_sel ? trig_act : !trig_act;

    // Readout ends a fixed number of cycles after it starts
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt          <= 0;
            readout_done <= 1'b0;
        end else begin
            readout_done <= (cnt == 1);
            if (readout_start)
                cnt <= RD_LEN;
            else if (cnt != 0)
                cnt <= cnt - 1;
        end
    end
endmodule : ess_far_model

/* testbench/exposure_shutter_sequencer_tb.sv */
// Register-driven bench for the exposure and shutter sequencer
`timescale 1ns/100ps
module exposure_shutter_sequencer_tb;
    logic        clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, ext_trig, shutter_open;
    logic        sync_out, readout_busy, readout_start, readout_done;
    logic        trig_act, rising_sel;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    int          n_errors, comparisons, cycles, n;

    ess_seq ess_seq_i (.clk(clk), .nrst(nrst), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .ext_trig(ext_trig),
        .shutter_open(shutter_open), .sync_out(sync_out),
        .readout_busy(readout_busy), .readout_start(readout_start),
        .readout_done(readout_done));
    ess_far_model ess_far_model_i (.clk(clk), .nrst(nrst),
        .trig_act(trig_act), .rising_sel(rising_sel),
        .readout_start(readout_start), .ext_trig(ext_trig),
        .readout_done(readout_done));

    // Clock at 125 MHz
    initial begin
        clk = 1'b0;
        forever #4 clk = !clk;
    end

    task automatic complete_run();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_cnt(input int got, input int exp);
        chk_word(got, exp);
    endtask : chk_cnt

    // AXI4-Lite write: address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bit aw_ok, w_ok;
        aw_ok = 0;
        w_ok = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (!aw_ok && awready) begin
                aw_ok = 1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1;
                wvalid <= 1'b0;
            end
        end while (!(aw_ok && w_ok));
        do @(posedge clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    // AXI4-Lite read: address held until taken, then wait for data
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd

    function automatic logic pick(input int s);
        return (s == 0) ? shutter_open : readout_busy;
    endfunction : pick

    // Count falling edges until a watched output reaches a level
    task automatic wait_for(input int s, input logic v, output int c);
        c = 0;
        while (pick(s) !== v && c < 3000) begin
            @(negedge clk);
            c++;
        end
    endtask : wait_for

    task automatic high_len(input int s, output int c);
        wait_for(s, 1'b1, c);
        c = 0;
        while (pick(s) === 1'b1 && c < 3000) begin
            c++;
            @(negedge clk);
        end
    endtask : high_len

    task automatic setup(input logic [31:0] ctrl, input logic [31:0] fr);
        wr(ess_pkg::OFS_CTRL, ctrl);
        wr(ess_pkg::OFS_FRAMES, fr);
        wr(ess_pkg::OFS_CMD, 32'h0000_0001);
    endtask : setup

    task automatic finish_run(input logic [31:0] frames);
        wait_for(1, 1'b1, n);
        wait_for(1, 1'b0, n);
        repeat (20) @(negedge clk);
        chk_word(32'(shutter_open), 32'h0);
        rd(ess_pkg::OFS_DONE_CNT);
        chk_word(d, frames);
    endtask : finish_run

    // Cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            complete_run();
        end
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, trig_act} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        rising_sel = 1'b0;
        n_errors = 0;
        comparisons = 0;
        cycles = 0;
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rd(ess_pkg::OFS_EXPOSURE);
        chk_word(d, 32'h0000_0064);
        rd(8'h1C);
        chk_word(d, 32'h0000_0000);
        chk_word(32'(r), 32'(ess_pkg::RESP_SLVERR));
        wr(8'h1C, 32'h0000_0005);
        chk_word(32'(r), 32'(ess_pkg::RESP_SLVERR));
        wr(ess_pkg::OFS_EXPOSURE, 32'h0000_0005);
        wr(ess_pkg::OFS_SETTLE, 32'h0000_0003);
        // Continuous, two frames, trigger pin active through the first exposure only
        trig_act <= 1'b1;
        setup(32'h0000_0000, 32'h0000_0002);
        high_len(0, n);
        chk_cnt(n, 6);
        @(posedge clk);
        trig_act <= 1'b0;
        wait_for(1, 1'b1, n);
        chk_cnt(n, 4);
        chk_word(32'(sync_out), 32'h0);
        wait_for(1, 1'b0, n);
        chk_word(32'(shutter_open), 32'h1);
        finish_run(32'h0000_0002);
        // Triggered normal timing, both edge polarities, sync shows shutter
        for (int e = 0; e < 2; e++) begin
            @(posedge clk);
            rising_sel <= e[0];
            setup(32'h0000_0021 | (e << 2), 32'h0000_0001);
            repeat (30) @(negedge clk);
            chk_word(32'(shutter_open), 32'h0);
            @(posedge clk);
            trig_act <= 1'b1;
            wait_for(0, 1'b1, n);
            chk_word(32'(sync_out), 32'h1);
            high_len(0, n);
            chk_cnt(n, 6);
            @(posedge clk);
            trig_act <= 1'b0;
            finish_run(32'h0000_0001);
        end
        // Early-open timing, falling edge, two frames
        @(posedge clk);
        rising_sel <= 1'b0;
        setup(32'h0000_0003, 32'h0000_0002);
        repeat (30) @(negedge clk);
        chk_word(32'(shutter_open), 32'h1);
        for (int f = 0; f < 2; f++) begin
            @(posedge clk);
            trig_act <= 1'b1;
            repeat (4) @(posedge clk);
            trig_act <= 1'b0;
            wait_for(0, 1'b0, n);
            wait_for(1, 1'b1, n);
            chk_cnt(n, 4);
            wait_for(1, 1'b0, n);
            if (f == 0) begin
                chk_word(32'(shutter_open), 32'h1);
                rd(ess_pkg::OFS_STATUS);
                chk_word(32'(d[2:0]), 32'h1);
            end
        end
        rd(ess_pkg::OFS_DONE_CNT);
        chk_word(d, 32'h0000_0002);
        // Trigger still active at readout end starts another frame
        setup(32'h0000_0001, 32'h0000_0002);
        trig_act <= 1'b1;
        wait_for(1, 1'b1, n);
        wait_for(1, 1'b0, n);
        chk_word(32'(shutter_open), 32'h1);
        @(posedge clk);
        trig_act <= 1'b0;
        finish_run(32'h0000_0002);
        // Shutter held open, then held closed, for a whole run
        for (int m = 1; m < 3; m++) begin
            setup(m << 3, 32'h0000_0001);
            wait_for(1, 1'b1, n);
            chk_word(32'(shutter_open), 32'(m == 1));
            wait_for(1, 1'b0, n);
        end
        complete_run();
    end
endmodule : exposure_shutter_sequencer_tb
